/* rtl/dmbscs_pkg.sv */
/*
 Shared constants and state types for both bus ends.
 Assumes a 100 MHz user clock at each end.
*/
package dmbscs_pkg;
  // User clock rate
  localparam int CLK_MHZ = 100;
  // Bus widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int CA_W   = 48;
  // Command/address cycles per frame
  localparam int CA_CYCLES = 6;
  // Initial latency in bus clocks
  localparam int LAT_CYCLES = 4;
  // Command bit positions
  localparam int CA_RD_BIT  = 47;
  localparam int CA_REG_BIT = 46;
  // Host clock divider, half period in cycles
  localparam int HALF_DIV = 8;
  // Gap with select high between frames
  localparam int GAP_CYC = 8;
  // Clock stable time before clock stop
  localparam int ACCESS_TIME_NS = 70;
  localparam int STOP_EXTRA_NS  = 30;
  localparam int STOP_CYC =
    ((ACCESS_TIME_NS + STOP_EXTRA_NS) * CLK_MHZ + 999) / 1000;
  // Longest select-low time
  localparam int CSM_NS  = 4000;
  localparam int CSM_CYC = (CSM_NS * CLK_MHZ) / 1000;
  // Reset values
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [7:0]  UPPER_FILL = 8'h00;
  // Device link states
  typedef enum logic [3:0] {
    DEV_CA  = 4'b0001,
    DEV_LAT = 4'b0010,
    DEV_RD  = 4'b0100,
    DEV_WR  = 4'b1000
  } dmbscs_dev_e;
  // Host sequencer states
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_RUN  = 3'b010,
    H_END  = 3'b100
  } dmbscs_host_e;
endpackage

/* rtl/dmbscs_if.sv */
/*
 Bus wires between host and device ends.
 Resolves shared lines from the output enables.
*/
`timescale 1ns/1ps
interface dmbscs_if;
  import dmbscs_pkg::*;
  logic              bus_clock;        // Host driven clock
  logic              clock_complement; // Complement clock
  logic              cs_n;             // Select, low active
  logic              reset_n;          // Link reset, low active
  logic [DATA_W-1:0] dq_h_o;           // Host data out
  logic              dq_h_oe;          // Host data enable
  logic [DATA_W-1:0] dq_d_o;           // Device data out
  logic              dq_d_oe;          // Device data enable
  logic [1:0]        strobe_mask_lines_h_o;         // Host mask out
  logic              strobe_mask_lines_h_oe;        // Host mask enable
  logic [1:0]        strobe_mask_lines_d_o;         // Device strobe out
  logic              strobe_mask_lines_d_oe;        // Device strobe enable
  logic [DATA_W-1:0] dq;               // Resolved data
  logic [1:0]        strobe_mask_lines;             // Resolved strobe/mask

  // Undriven lines read low
  assign dq   = dq_d_oe ? dq_d_o : (dq_h_oe ? dq_h_o : '0);
  assign strobe_mask_lines = strobe_mask_lines_d_oe ? strobe_mask_lines_d_o :
                (strobe_mask_lines_h_oe ? strobe_mask_lines_h_o : 2'b00);

  modport host (
    output bus_clock, clock_complement, cs_n, reset_n,
    output dq_h_o, dq_h_oe, strobe_mask_lines_h_o, strobe_mask_lines_h_oe,
    input  dq, strobe_mask_lines
  );
  modport device (
    input  bus_clock, clock_complement, cs_n, reset_n,
    output dq_d_o, dq_d_oe, strobe_mask_lines_d_o, strobe_mask_lines_d_oe,
    input  dq, strobe_mask_lines
  );
endinterface

/* rtl/dmbscs_clkstop.sv */
/*
 Clock stop and standby detector on the device clock.
 Assumes bus clock and select arrive as raw pins.
*/
`timescale 1ns/1ps
module dmbscs_clkstop #(
  parameter int STOP = dmbscs_pkg::STOP_CYC
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic bus_clock_pin,
  input  wire logic cs_n_pin,
  output logic      clock_stop,
  output logic      standby
);
  import dmbscs_pkg::*;
  localparam int QW = $clog2(STOP + 1);
  localparam logic [QW-1:0] QMAX = QW'(STOP);

  logic          ck_s1_ff, ck_s2_ff, ck_s3_ff; // Clock sync
  logic          cs_s1_ff, cs_s2_ff;           // Select sync
  logic [QW-1:0] quiet_ff;                     // Stable time
  logic [QW-1:0] nxt_quiet;
  logic          edge_seen;                    // Any clock edge

  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      {ck_s1_ff, ck_s2_ff, ck_s3_ff} <= 3'b000;
      {cs_s1_ff, cs_s2_ff} <= 2'b11;
    end else begin
      {ck_s1_ff, ck_s2_ff, ck_s3_ff} <=
        {bus_clock_pin, ck_s1_ff, ck_s2_ff};
      {cs_s1_ff, cs_s2_ff} <= {cs_n_pin, cs_s1_ff};
    end
  end

  // Timer clears on every edge or out of frame
  assign edge_seen = ck_s2_ff ^ ck_s3_ff;
  always_comb begin
    nxt_quiet = quiet_ff;
    if (edge_seen || cs_s2_ff) begin
      nxt_quiet = '0;
    end else if (quiet_ff != QMAX) begin
      nxt_quiet = quiet_ff + 1'b1;
    end
  end

  // Stop flag set once stable long enough
  always_ff @(posedge clock) begin
    if (!resetn) begin
      quiet_ff   <= '0;
      clock_stop <= 1'b0;
      standby    <= 1'b1;
    end else begin
      quiet_ff   <= nxt_quiet;
      clock_stop <= (nxt_quiet == QMAX);
      standby    <= cs_s2_ff;
    end
  end
endmodule

/* rtl/dmbscs_device.sv */
/*
 Memory device end of the bus, with small array and one
 config word. Assumes host drives clock, select, reset.
 The refresh level crosses on bus clock edges only, so it
 must stand through one frame before a frame can flag it.
*/
`timescale 1ns/1ps
module dmbscs_device #(
  parameter int DEPTH = 1 << dmbscs_pkg::ADDR_W,
  parameter int LAT   = dmbscs_pkg::LAT_CYCLES
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic refresh_busy,
  output logic      clock_stop,
  output logic      standby,
  dmbscs_if.device  bus
);
  import dmbscs_pkg::*;
  localparam int CW = $clog2(2 * LAT + CA_CYCLES);
  localparam logic [CW-1:0] CA_LAST  = CW'(CA_CYCLES - 1);
  localparam logic [CW-1:0] LAT_LAST = CW'(LAT - 1);
  localparam logic [CW-1:0] LAT2_LAST = CW'(2 * LAT - 1);

  dmbscs_dev_e       state_ff;      // Link state
  logic [CW-1:0]     cnt_ff;        // Cycle in phase
  logic [CA_W-1:0]   ca_ff;         // Command word
  logic [CA_W-1:0]   nxt_ca;
  logic              extra_ff;      // Doubled latency
  logic [ADDR_W-1:0] addr_ff;       // Word pointer
  logic [DATA_W-1:0] mem_ff [DEPTH];// Storage array
  logic [DATA_W-1:0] cfg_ff;        // Config word
  logic [DATA_W-1:0] rd_word;       // Word to send
  logic              refresh_ff;    // Registered request
  logic              ref_s1_ff;     // Refresh sync stage 1
  logic              ref_s2_ff;     // Refresh sync stage 2
  logic              end_frame;     // Frame end or link reset
  logic              lat_last;      // Last latency cycle
  logic              is_read;
  logic              is_reg;
  logic              ca_done;
  logic              zero_lat;      // Register write

  // Frame ends asynchronously on select high
  assign end_frame = bus.cs_n | ~bus.reset_n;
  assign nxt_ca   = {ca_ff[CA_W-9:0], bus.dq[7:0]};
  assign is_read  = ca_ff[CA_RD_BIT];
  assign is_reg   = ca_ff[CA_REG_BIT];
  assign ca_done  = (state_ff == DEV_CA) && (cnt_ff == CA_LAST);
  assign zero_lat = !nxt_ca[CA_RD_BIT] && nxt_ca[CA_REG_BIT];
  assign lat_last = (cnt_ff == (extra_ff ? LAT2_LAST : LAT_LAST));
  assign rd_word  = is_reg ? cfg_ff : mem_ff[addr_ff];

  // Refresh request registered on own clock
  always_ff @(posedge clock) begin
    if (!resetn) begin
      refresh_ff <= 1'b0;
    end else begin
      refresh_ff <= refresh_busy;
    end
  end

  // Refresh level into the link domain
  always_ff @(posedge bus.bus_clock or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
    end else begin
      ref_s1_ff <= refresh_ff;
      ref_s2_ff <= ref_s1_ff;
    end
  end

  // Phase sequencer and word pointer
  always_ff @(posedge bus.bus_clock or posedge end_frame) begin
    if (end_frame) begin
      state_ff <= DEV_CA;
      cnt_ff   <= '0;
      ca_ff    <= '0;
      extra_ff <= 1'b0;
      addr_ff  <= '0;
    end else begin
      unique case (state_ff)
        // Gather command bytes
        DEV_CA: begin
          ca_ff <= nxt_ca;
          if (cnt_ff == '0) begin
            extra_ff <= ref_s2_ff;
          end
          if (ca_done) begin
            cnt_ff  <= '0;
            addr_ff <= nxt_ca[ADDR_W-1:0];
            // Zero latency skips turnaround
            state_ff <= zero_lat ? DEV_WR : DEV_LAT;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        // Count initial latency
        DEV_LAT: begin
          if (lat_last) begin
            cnt_ff   <= '0;
            state_ff <= is_read ? DEV_RD : DEV_WR;
            if (is_read) begin
              addr_ff <= addr_ff + 1'b1;
            end
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        // One word per rising edge, none when clock is held
        DEV_RD, DEV_WR: begin
          addr_ff <= addr_ff + 1'b1;
        end
      endcase
    end
  end

  // Strobe and data pin drive
  always_ff @(posedge bus.bus_clock or posedge end_frame) begin
    if (end_frame) begin
      bus.strobe_mask_lines_d_o  <= 2'b00;
      bus.strobe_mask_lines_d_oe <= 1'b0;
      bus.dq_d_o    <= '0;
      bus.dq_d_oe   <= 1'b0;
    end else begin
      unique case (state_ff)
        // Latency request during command phase
        DEV_CA: begin
          bus.strobe_mask_lines_d_oe <= 1'b1;
          if (cnt_ff == '0) begin
            // High asks for extra latency
            bus.strobe_mask_lines_d_o <= {2{ref_s2_ff}};
          end
          if (ca_done) begin
            bus.strobe_mask_lines_d_o <= 2'b00;
            // Release only for masked writes
            bus.strobe_mask_lines_d_oe <= nxt_ca[CA_RD_BIT] || zero_lat;
          end
        end
        // Read: first word at end of latency
        DEV_LAT: begin
          if (lat_last && is_read) begin
            bus.dq_d_o    <= rd_word;
            bus.dq_d_oe   <= 1'b1;
            bus.strobe_mask_lines_d_o  <= 2'b11;
          end
        end
        // Read burst; held while clock stands
        DEV_RD: begin
          bus.dq_d_o   <= rd_word;
          bus.strobe_mask_lines_d_o <= ~bus.strobe_mask_lines_d_o;
        end
        // Write: pins as left by command phase
        DEV_WR: begin
          bus.dq_d_oe <= 1'b0;
        end
      endcase
    end
  end

  // Array writes, masked unless zero latency
  always_ff @(posedge bus.bus_clock) begin
    if (!end_frame && state_ff == DEV_WR && !is_reg) begin
      for (int b = 0; b < 2; b++) begin
        // Mask bit high keeps the byte
        if (!bus.strobe_mask_lines[b]) begin
          mem_ff[addr_ff][b*8 +: 8] <= bus.dq[b*8 +: 8];
        end
      end
    end
  end

  // Config word, written whole
  always_ff @(posedge bus.bus_clock or negedge bus.reset_n) begin
    if (!bus.reset_n) begin
      cfg_ff <= CFG_RESET;
    end else if (!bus.cs_n && state_ff == DEV_WR && is_reg) begin
      cfg_ff <= bus.dq;
    end
  end

  // Clock stop and standby status
  dmbscs_clkstop #(
    .STOP (STOP_CYC)
  ) u_clkstop (
    .clock         (clock),
    .resetn        (resetn),
    .bus_clock_pin (bus.bus_clock),
    .cs_n_pin      (bus.cs_n),
    .clock_stop    (clock_stop),
    .standby       (standby)
  );
endmodule

/* rtl/dmbscs_host.sv */
/*
 Host controller end: one word per frame, clock made by a
 divider. Assumes device end on the same interface.
*/
`timescale 1ns/1ps
module dmbscs_host #(
  parameter int HALF = dmbscs_pkg::HALF_DIV,
  parameter int LAT  = dmbscs_pkg::LAT_CYCLES,
  parameter int CSM  = dmbscs_pkg::CSM_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_read,
  input  wire logic                          cmd_reg,
  input  wire logic [dmbscs_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [dmbscs_pkg::DATA_W-1:0] cmd_wdata,
  input  wire logic [1:0]                    cmd_mask,
  input  wire logic                          pause_req,
  output logic                               cmd_ready,
  output logic                               rsp_valid,
  output logic [dmbscs_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                               rsp_abort,
  dmbscs_if.host                             bus
);
  import dmbscs_pkg::*;
  localparam int SW = 6;
  localparam logic [SW-1:0] CA_N = SW'(CA_CYCLES);
  localparam logic [SW-1:0] L1   = SW'(LAT);

  dmbscs_host_e      state_ff;   // Sequencer
  logic [7:0]        div_ff;     // Half period count
  logic [SW-1:0]     step_ff;    // Rising edges done
  logic [15:0]       csm_ff;     // Select-low time
  logic [CA_W-1:0]   ca_ff;      // Bytes still to send
  logic              rd_ff, zl_ff, reg_ff;
  logic              extra_ff;   // Device asked for more
  logic [DATA_W-1:0] wdata_ff;
  logic [1:0]        mask_ff;
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
  logic [1:0]        rw_s1_ff, rw_s2_ff;
  logic [SW-1:0]     data_idx;   // Edge of data word
  logic [SW-1:0]     leff;
  logic              hold;       // Clock held low
  logic              half_end;

  assign leff     = extra_ff ? (L1 + L1) : L1;
  assign data_idx = zl_ff ? CA_N : (rd_ff ? CA_N - 1'b1 + leff
                                         : CA_N + leff);
  // Pause only with clock low, not on registers
  assign hold     = pause_req && !reg_ff && !bus.bus_clock;
  assign half_end = (div_ff == 8'(HALF - 1)) && !hold;

  // Pin input synchronisers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      rw_s1_ff <= 2'b00;
      rw_s2_ff <= 2'b00;
    end else begin
      dq_s1_ff <= bus.dq;
      dq_s2_ff <= dq_s1_ff;
      rw_s1_ff <= bus.strobe_mask_lines;
      rw_s2_ff <= rw_s1_ff;
    end
  end

  // Frame sequencer, clock divider, pin drive
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff <= H_IDLE;
      div_ff <= '0;
      step_ff <= '0;
      csm_ff <= '0;
      ca_ff <= '0;
      {rd_ff, zl_ff, reg_ff, extra_ff} <= 4'b0000;
      wdata_ff <= '0;
      mask_ff <= 2'b00;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_abort <= 1'b0;
      bus.reset_n <= 1'b0;
      bus.cs_n <= 1'b1;
      bus.bus_clock <= 1'b0;
      bus.clock_complement <= 1'b1;
      bus.dq_h_o <= '0;
      bus.dq_h_oe <= 1'b0;
      bus.strobe_mask_lines_h_o <= 2'b00;
      bus.strobe_mask_lines_h_oe <= 1'b0;
    end else begin
      bus.reset_n <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_abort <= 1'b0;
      unique case (state_ff)
        // Take a command, open the frame
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            rd_ff <= cmd_read;
            reg_ff <= cmd_reg;
            zl_ff <= !cmd_read && cmd_reg;
            extra_ff <= 1'b0;
            wdata_ff <= cmd_wdata;
            mask_ff <= cmd_mask;
            ca_ff <= {cmd_read, cmd_reg,
                      {(CA_W-2-ADDR_W){1'b0}}, cmd_addr} << 8;
            bus.dq_h_o <= {UPPER_FILL, cmd_read, cmd_reg, 6'h00};
            bus.dq_h_oe <= 1'b1;
            bus.cs_n <= 1'b0;
            div_ff <= '0;
            step_ff <= '0;
            csm_ff <= '0;
            state_ff <= H_RUN;
          end
        end
        // Run the bus clock and step the frame
        H_RUN: begin
          csm_ff <= csm_ff + 1'b1;
          if (csm_ff == 16'(CSM - 1)) begin
            // Close before select-low limit
            bus.cs_n <= 1'b1;
            bus.bus_clock <= 1'b0;
            bus.clock_complement <= 1'b1;
            bus.dq_h_oe <= 1'b0;
            bus.strobe_mask_lines_h_oe <= 1'b0;
            rsp_abort <= 1'b1;
            div_ff <= '0;
            state_ff <= H_END;
          end else if (half_end) begin
            div_ff <= '0;
            bus.bus_clock <= !bus.bus_clock;
            bus.clock_complement <= bus.bus_clock;
            if (!bus.bus_clock) begin
              step_ff <= step_ff + 1'b1;
            end else begin
              // Falling edge: sample, set next
              if (step_ff == 6'd1) begin
                extra_ff <= rw_s2_ff[0];
              end
              if (step_ff < CA_N) begin
                bus.dq_h_o <= {UPPER_FILL, ca_ff[CA_W-1 -: 8]};
                ca_ff <= ca_ff << 8;
              end else if (rd_ff) begin
                bus.dq_h_oe <= 1'b0;
              end
              if (!rd_ff && step_ff == data_idx) begin
                bus.dq_h_o <= wdata_ff;
                bus.strobe_mask_lines_h_o <= mask_ff;
                bus.strobe_mask_lines_h_oe <= !zl_ff;
              end
              if (step_ff == data_idx + 1'b1) begin
                bus.cs_n <= 1'b1;
                bus.dq_h_oe <= 1'b0;
                bus.strobe_mask_lines_h_oe <= 1'b0;
                rsp_rdata <= rd_ff ? dq_s2_ff : '0;
                rsp_valid <= 1'b1;
                state_ff <= H_END;
              end
            end
          end else if (!hold) begin
            div_ff <= div_ff + 1'b1;
          end
        end
        // Select high gap before next frame
        H_END: begin
          div_ff <= div_ff + 1'b1;
          if (div_ff == 8'(GAP_CYC - 1)) begin
            div_ff <= '0;
            state_ff <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* sim/dmbscs_props.sv */
/*
 Concurrent checks on the bus wires between host and device.
 Assumes it is instantiated beside the interface, sampled on
 the host user clock with its synchronous low reset.
*/
`timescale 1ns/1ps
module dmbscs_props
  import dmbscs_pkg::*;
#(
  parameter int CSM  = CSM_CYC,  // Select-low limit in cycles
  parameter int HALF = HALF_DIV  // Bus clock half period
) (
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic              bus_clock,
  input wire logic              clock_complement,
  input wire logic              cs_n,
  input wire logic              dq_h_oe,
  input wire logic              strobe_mask_lines_h_oe,
  input wire logic [DATA_W-1:0] dq_d_o,
  input wire logic              dq_d_oe,
  input wire logic [1:0]        strobe_mask_lines_d_o,
  input wire logic              strobe_mask_lines_d_oe
);
  logic [15:0] lo_ff;  // Cycles with select low
  logic [15:0] hi_ff;  // Cycles with bus clock high

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // Count the select-low stretch
  always_ff @(posedge clock) begin
    if (!resetn || cs_n) lo_ff <= '0;
    else lo_ff <= lo_ff + 16'h0001;
  end

  // Count the bus clock high stretch
  always_ff @(posedge clock) begin
    if (!resetn || !bus_clock) hi_ff <= '0;
    else hi_ff <= hi_ff + 16'h0001;
  end

  property p_cmp;
    clock_complement == !bus_clock;
  endproperty
  property p_idle_low;
    cs_n |-> !bus_clock && clock_complement;
  endproperty
  property p_standby;
    cs_n |-> !dq_d_oe && !strobe_mask_lines_d_oe;
  endproperty
  property p_one_strobe;
    !(strobe_mask_lines_d_oe && strobe_mask_lines_h_oe);
  endproperty
  property p_ca_strobe;
    $fell(cs_n) |-> ##[1:24] strobe_mask_lines_d_oe;
  endproperty
  property p_ca_drive;
    $fell(cs_n) |-> dq_h_oe;
  endproperty
  property p_stop_low;
    hi_ff <= 16'(HALF + 1);
  endproperty
  property p_csm;
    lo_ff <= 16'(CSM + 2);
  endproperty
  property p_read_hold;
    !cs_n && dq_d_oe && $past(dq_d_oe) && $stable(bus_clock)
      |-> $stable(dq_d_o);
  endproperty

  a_cmp: assert property (p_cmp) else $error("complement wrong");
  a_idle_low: assert property (p_idle_low) else $error("idle clock");
  a_standby: assert property (p_standby) else $error("standby drive");
  a_one_strobe: assert property (p_one_strobe) else $error("strobe_mask_lines clash");
  a_ca_strobe: assert property (p_ca_strobe) else $error("no ca strobe");
  a_ca_drive: assert property (p_ca_drive) else $error("lanes undriven");
  a_stop_low: assert property (p_stop_low) else $error("clock held high");
  a_csm: assert property (p_csm) else $error("select low too long");
  a_read_hold: assert property (p_read_hold) else $error("word moved");

  // Main scenarios reached
  c_frame: cover property ($fell(cs_n));
  c_refresh: cover property (strobe_mask_lines_d_oe && strobe_mask_lines_d_o == 2'b11 && lo_ff < 24);
  c_long: cover property (lo_ff > 16'd300);
endmodule

/* sim/tb_ddr_memory_bus_states_clock_stop.sv */
/*
 Self-checking bench: host and device joined by the interface,
 command port driven with a word model of array and config.
 Assumes the host makes the bus clock from its own clock.
*/
`timescale 1ns/1ps
module tb_ddr_memory_bus_states_clock_stop;
  import dmbscs_pkg::*;
  logic              clock, dclk, resetn;    // Clocks and reset
  logic              cmd_valid, cmd_read;    // Command strobe, kind
  logic              cmd_reg, pause_req;     // Space, clock pause
  logic              refresh_busy;           // Device refresh busy
  logic [ADDR_W-1:0] cmd_addr;               // Word address
  logic [DATA_W-1:0] cmd_wdata, rsp_rdata;   // Write and read word
  logic [1:0]        cmd_mask;               // Byte masks
  logic              cmd_ready, rsp_valid;   // Host answers
  logic              rsp_abort, clock_stop;  // Abort, clock stop
  logic              standby;                // Device standby
  logic [15:0]       mem_m [16];             // Array model
  logic [15:0]       cfg_m;                  // Config model
  logic [31:0]       seed;                   // Random state
  int                err_total, tests_run;   // Counters
  int                cyc, cyc0, i;           // Frame lengths
  logic              ab;                     // Abort seen

  dmbscs_if u_dmbscs_if ();
  dmbscs_host u_dmbscs_host (.clock(clock), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_reg(cmd_reg),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_mask(cmd_mask),
    .pause_req(pause_req), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_abort(rsp_abort), .bus(u_dmbscs_if));
  dmbscs_device u_dmbscs_device (.clock(dclk), .resetn(resetn),
    .refresh_busy(refresh_busy), .clock_stop(clock_stop),
    .standby(standby), .bus(u_dmbscs_if));
  dmbscs_props u_dmbscs_props (.clock(clock), .resetn(resetn),
    .bus_clock(u_dmbscs_if.bus_clock),
    .clock_complement(u_dmbscs_if.clock_complement),
    .cs_n(u_dmbscs_if.cs_n), .dq_h_oe(u_dmbscs_if.dq_h_oe),
    .strobe_mask_lines_h_oe(u_dmbscs_if.strobe_mask_lines_h_oe), .dq_d_o(u_dmbscs_if.dq_d_o),
    .dq_d_oe(u_dmbscs_if.dq_d_oe), .strobe_mask_lines_d_o(u_dmbscs_if.strobe_mask_lines_d_o),
    .strobe_mask_lines_d_oe(u_dmbscs_if.strobe_mask_lines_d_oe));

  // Host user clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Device clock, same rate, shifted phase
  initial begin
    dclk = 1'b0;
    #3;
    forever #5 dclk = ~dclk;
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Compare one value
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One frame; pause of pl cycles from cycle pd
  task automatic xfer(input logic rd, input logic rg,
                      input logic [3:0] a, input logic [15:0] wd,
                      input logic [1:0] m, input int pd, input int pl);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_reg   = rg;
    cmd_addr  = a;
    cmd_wdata = wd;
    cmd_mask  = m;
    n = 0;
    // Ready seen settled; the next rising edge takes
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    cyc = 1;
    while (rsp_valid !== 1'b1 && rsp_abort !== 1'b1 && cyc < 2000) begin
      @(negedge clock);
      cyc++;
      pause_req = (cyc >= pd && cyc < pd + pl);
      if (cyc == 20) check("standby", standby, 1'b0);
      if (pl == 40 && cyc == pd + pl - 1)
        check("clock_stop", clock_stop, 1'b1);
      if (pl == 40 && cyc == pd + pl + 20)
        check("clock_stop", clock_stop, 1'b0);
    end
    pause_req = 1'b0;
    ab = rsp_abort;
    if (n >= 200 || cyc >= 2000) begin
      err_total++;
      $display("ERROR wait expected answer seen none");
      stop_test();
    end
    if (rd && !ab) check("rdata", rsp_rdata, rg ? cfg_m : mem_m[a]);
    if (!rd && rg) cfg_m = wd;
    for (n = 0; n < 2 && !rd && !rg; n++) begin
      if (!m[n]) mem_m[a][8*n +: 8] = wd[8*n +: 8];
    end
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_reg = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
    cmd_mask = '0;
    pause_req = 1'b0;
    refresh_busy = 1'b0;
    seed = 32'h0000_ee6b;
    err_total = 0;
    tests_run = 0;
    cfg_m = CFG_RESET;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    check("standby", standby, 1'b1);
    check("clock_stop", clock_stop, 1'b0);
    xfer(1'b1, 1'b1, 4'h0, 16'h0000, 2'b00, 0, 0);
    xfer(1'b0, 1'b1, 4'h0, 16'(rnd()), 2'b11, 0, 0);
    xfer(1'b1, 1'b1, 4'h0, 16'h0000, 2'b00, 0, 0);
    $display("test register done");
    for (i = 0; i < 16; i++)
      xfer(1'b0, 1'b0, 4'(i), 16'(rnd()), 2'b00, 0, 0);
    repeat (8)
      xfer(1'b0, 1'b0, 4'(rnd()), 16'(rnd()), 2'(rnd()), 0, 0);
    for (i = 0; i < 16; i++) xfer(1'b1, 1'b0, 4'(i), 16'h0000, 2'b00, 0, 0);
    cyc0 = cyc;
    $display("test array done");
    // Level reaches the link side over one frame of edges
    refresh_busy = 1'b1;
    xfer(1'b1, 1'b0, 4'h2, 16'h0000, 2'b00, 0, 0);
    xfer(1'b1, 1'b0, 4'h3, 16'h0000, 2'b00, 0, 0);
    check("latency", 16'(cyc - cyc0), 16'(2 * HALF_DIV * LAT_CYCLES));
    refresh_busy = 1'b0;
    xfer(1'b1, 1'b0, 4'h2, 16'h0000, 2'b00, 0, 0);
    check("latency", 16'(cyc - cyc0), 16'(2 * HALF_DIV * LAT_CYCLES));
    xfer(1'b1, 1'b0, 4'h4, 16'h0000, 2'b00, 0, 0);
    check("latency", 16'(cyc), 16'(cyc0));
    $display("test refresh done");
    xfer(1'b1, 1'b0, 4'h5, 16'h0000, 2'b00, 130, 40);
    xfer(1'b0, 1'b0, 4'h6, 16'(rnd()), 2'b01, 130, 40);
    xfer(1'b1, 1'b0, 4'h6, 16'h0000, 2'b00, 0, 0);
    $display("test pause done");
    xfer(1'b1, 1'b0, 4'h7, 16'h0000, 2'b00, 60, 500);
    check("abort", ab, 1'b1);
    xfer(1'b1, 1'b0, 4'h7, 16'h0000, 2'b00, 0, 0);
    $display("test abort done");
    stop_test();
  end
endmodule
